/* src/pgfs_top.v */
// Operation
// RULE_01 - each group-0 pin has a mode bit, 0 gpio and 1 peripheral.
// RULE_02 - the upper byte of the mode register reads zero, no storage.
// RULE_03 - each group-0 pin has a 2-bit function field, pin 7 on top.
// RULE_04 - pins 0 and 1 function 0 feed timer channel 0 clock inputs.
// RULE_05 - pin 2 function 0 is buzzer output, pin 3 its inverse.
// RULE_06 - pins 4, 5 function 0 are converter clocks 0, 1; 6, 7 none.
// RULE_07 - function 1 is the universal multiplexer, 2 and 3 are unused.
// RULE_08 - group 1 is gpio and pin events only, no function muxing.
// RULE_09 - group-1 data bits 15..8 are output latches driven to pins.
// RULE_10 - group-1 data bits 7..0 read the current pin input levels.
// RULE_11 - mode, function and latch bits reset to zero, all gpio.
// RULE_12 - bits of pins not bonded out read zero and ignore writes.
//
// Decided for this implementation: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
`include "pgfs_regs.vh"
module pgfs_top #(
    parameter [7:0] G0_BONDED = `PGFS_G0_BONDED,
    parameter [7:0] G1_BONDED = `PGFS_G1_BONDED
) (
    // clock and reset
    input  wire        aclk,
    input  wire        aresetn,
    // axi4-lite write address
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    // axi4-lite write data
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    // axi4-lite write response
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    // axi4-lite read address
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    // axi4-lite read data
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // group 0 pins
    input  wire [7:0]  g0_pin_in,
    output reg  [7:0]  g0_pin_out,
    output reg  [7:0]  g0_pin_oe,
    // group 0 gpio side
    input  wire [7:0]  g0_gpio_out,
    input  wire [7:0]  g0_gpio_oe,
    output reg  [7:0]  g0_gpio_in,
    // group 0 peripheral side
    input  wire        buzzer_output,
    input  wire        buzzer_output_n,
    input  wire        buzzer_oe,
    input  wire [1:0]  converter_clock_out,
    input  wire [1:0]  converter_clock_oe,
    output reg  [1:0]  timer_ext_clock_in,
    input  wire [7:0]  universal_pin_multiplexer_out,
    input  wire [7:0]  universal_pin_multiplexer_oe,
    output reg  [7:0]  universal_pin_multiplexer_in,
    // group 1 pins
    input  wire [7:0]  g1_pin_in,
    output reg  [7:0]  g1_pin_out,
    input  wire [7:0]  g1_gpio_oe,
    // interrupt
    output reg         irq
);

    // ------------------------------------------------------------------
    // registers and synchronisers
    // ------------------------------------------------------------------
    reg  [7:0]  pin_peripheral_mode_bit;
    reg  [15:0] pin_function_field;
    reg  [7:0]  group1_output_latch;
    reg  [7:0]  irq_stat;
    reg  [7:0]  irq_mask;
    reg  [7:0]  g0_sync1;
    reg  [7:0]  g0_sync2;
    reg  [7:0]  g1_sync1;
    reg  [7:0]  group1_input_level;
    reg  [7:0]  g1_prev;
    reg  [1:0]  g1_warm;
    reg         aw_held;
    reg         w_held;
    reg  [7:0]  aw_addr;
    reg  [31:0] w_data;
    reg  [3:0]  w_strb;

    wire [7:0]  fn0_out;
    wire [7:0]  fn0_oe;
    wire [7:0]  mux_out;
    wire [7:0]  mux_oe;
    wire [7:0]  fn0_in_en;
    wire [7:0]  upmx_in_en;
    wire [7:0]  g1_edge;
    wire [15:0] g0_field_mask;

    // known offset check, used by both read and write paths
    function is_mapped;
        input [7:0] a;
        begin
            is_mapped = (a == `PGFS_OFS_MODE)   ||
                        (a == `PGFS_OFS_FUNC)   ||
                        (a == `PGFS_OFS_G1DATA) ||
                        (a == `PGFS_OFS_IRQ_STAT) ||
                        (a == `PGFS_OFS_IRQ_MASK);
        end
    endfunction

    // spread an 8-bit pin mask to 2-bit fields
    function [15:0] widen;
        input [7:0] m;
        integer k;
        begin
            widen = 16'h0000;
            for (k = 0; k < 8; k = k + 1) begin
                widen[2*k]   = m[k];
                widen[2*k+1] = m[k];
            end
        end
    endfunction

    // ------------------------------------------------------------------
    // function 0 sources by pin
    // ------------------------------------------------------------------
    // bonding mask spread over the 2-bit function fields
    assign g0_field_mask = widen(G0_BONDED);

    // pins 0,1 are timer inputs so never drive; 6,7 have nothing
    assign fn0_out = {2'b00, converter_clock_out,
                      buzzer_output_n, buzzer_output, 2'b00}; // RULE_05
    assign fn0_oe  = {2'b00, converter_clock_oe,
                      buzzer_oe, buzzer_oe, 2'b00}; // RULE_06

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1) begin : g_pin
            pgfs_pin_mux #(
                .PIN (gi)
            ) u_mux (
                .periph_mode (pin_peripheral_mode_bit[gi]),
                .func_sel    (pin_function_field[2*gi+1:2*gi]), // RULE_03
                .fn0_out     (fn0_out[gi]),
                .fn0_oe      (fn0_oe[gi]),
                .upmx_out    (universal_pin_multiplexer_out[gi]),
                .upmx_oe     (universal_pin_multiplexer_oe[gi]),
                .gpio_out    (g0_gpio_out[gi]),
                .gpio_oe     (g0_gpio_oe[gi]),
                .pin_out     (mux_out[gi]),
                .pin_oe      (mux_oe[gi]),
                .fn0_in_en   (fn0_in_en[gi]),
                .upmx_in_en  (upmx_in_en[gi])
            );
        end
    endgenerate

    // ------------------------------------------------------------------
    // pin sampling and registered outputs
    // ------------------------------------------------------------------
    // only the second stage of each synchroniser feeds logic; detection
    // waits until the previous-level copy holds a real pin level, since
    // a pin idling high would otherwise look like an edge after reset.
    // the price: a change in the first cycles after reset is not seen
    assign g1_edge = (g1_warm == `PGFS_G1_WARM)
                     ? ((group1_input_level ^ g1_prev) & G1_BONDED)
                     : 8'h00;

    // arming counter for pin-change detection
    always @(posedge aclk) begin
        if (!aresetn) begin
            g1_warm <= 2'h0;
        end else if (g1_warm != `PGFS_G1_WARM) begin
            g1_warm <= g1_warm + 2'h1;
        end
    end

    // registered pin paths cost one cycle but keep outputs glitch free
    always @(posedge aclk) begin
        if (!aresetn) begin
            g0_sync1   <= 8'h00;
            g0_sync2   <= 8'h00;
            g1_sync1   <= 8'h00;
            group1_input_level <= 8'h00;
            g1_prev    <= 8'h00;
            g0_pin_out <= 8'h00;
            g0_pin_oe  <= 8'h00;
            g0_gpio_in <= 8'h00;
            timer_ext_clock_in <= 2'h0;
            universal_pin_multiplexer_in <= 8'h00;
            g1_pin_out <= 8'h00;
        end else begin
            g0_sync1   <= g0_pin_in;
            g0_sync2   <= g0_sync1;
            g1_sync1   <= g1_pin_in;
            group1_input_level <= g1_sync1; // RULE_10
            g1_prev    <= group1_input_level;
            g0_pin_out <= mux_out & G0_BONDED;
            g0_pin_oe  <= mux_oe & G0_BONDED;
            g0_gpio_in <= g0_sync2 & ~pin_peripheral_mode_bit; // RULE_01
            timer_ext_clock_in <= g0_sync2[1:0] & fn0_in_en[1:0]; // RULE_04
            universal_pin_multiplexer_in <= g0_sync2 & upmx_in_en;
            // gpio only: the latch reaches the pins only where g1_gpio_oe is set
            g1_pin_out <= group1_output_latch & g1_gpio_oe; // RULE_08 RULE_09
        end
    end

    // ------------------------------------------------------------------
    // axi4-lite write channel
    // ------------------------------------------------------------------
    // address and data accepted in either order, response after both
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_held  <= 1'b0;
            w_held   <= 1'b0;
            aw_addr  <= 8'h00;
            w_data   <= 32'h0000_0000;
            w_strb   <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `PGFS_RESP_OKAY;
        end else begin
            s_axi_awready <= !aw_held && !s_axi_awready && !s_axi_bvalid
                             && s_axi_awvalid;
            s_axi_wready  <= !w_held && !s_axi_wready && !s_axi_bvalid
                             && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (aw_held && w_held) begin
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= is_mapped(aw_addr) ? `PGFS_RESP_OKAY
                                                   : `PGFS_RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // register store and event flags
    // ------------------------------------------------------------------
    // writes land in the cycle the response is raised; unbonded bits
    // are masked so they neither store nor read back
    always @(posedge aclk) begin
        if (!aresetn) begin
            pin_peripheral_mode_bit <= `PGFS_RST_BYTE; // RULE_11
            pin_function_field      <= `PGFS_RST_FUNC; // RULE_11
            group1_output_latch     <= `PGFS_RST_BYTE; // RULE_11
            irq_stat <= 8'h00;
            irq_mask <= 8'h00;
            irq      <= 1'b0;
        end else begin
            if (aw_held && w_held) begin
                case (aw_addr)
                    `PGFS_OFS_MODE: begin
                        // upper byte has no storage
                        if (w_strb[0])
                            pin_peripheral_mode_bit <=
                                w_data[7:0] & G0_BONDED; // RULE_02 RULE_12
                    end
                    `PGFS_OFS_FUNC: begin
                        // unbonded pins keep a zero field
                        if (w_strb[0])
                            pin_function_field[7:0] <=
                                w_data[7:0] & g0_field_mask[7:0]; // RULE_03
                        if (w_strb[1])
                            pin_function_field[15:8] <=
                                w_data[15:8] & g0_field_mask[15:8]; // RULE_12
                    end
                    `PGFS_OFS_G1DATA: begin
                        // lower byte is input only
                        if (w_strb[1])
                            group1_output_latch <=
                                w_data[15:8] & G1_BONDED; // RULE_09 RULE_12
                    end
                    `PGFS_OFS_IRQ_MASK: begin
                        if (w_strb[0])
                            irq_mask <= w_data[7:0] & G1_BONDED;
                    end
                    default: begin
                    end
                endcase
            end
            // new edge wins over a write-one clear in the same cycle
            if (aw_held && w_held && (aw_addr == `PGFS_OFS_IRQ_STAT)
                && w_strb[0])
                irq_stat <= (irq_stat & ~w_data[7:0]) | g1_edge; // RULE_08
            else
                irq_stat <= irq_stat | g1_edge;
            irq <= |(irq_stat & irq_mask);
        end
    end

    // ------------------------------------------------------------------
    // axi4-lite read channel
    // ------------------------------------------------------------------
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `PGFS_RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid
                             && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= is_mapped(s_axi_araddr) ? `PGFS_RESP_OKAY
                                                        : `PGFS_RESP_SLVERR;
                case (s_axi_araddr)
                    `PGFS_OFS_MODE:
                        s_axi_rdata <= {24'h000000,
                                        pin_peripheral_mode_bit}; // RULE_02
                    `PGFS_OFS_FUNC:
                        s_axi_rdata <= {16'h0000, pin_function_field};
                    `PGFS_OFS_G1DATA:
                        // unbonded input bits read as zero
                        s_axi_rdata <= {16'h0000, group1_output_latch,
                                        group1_input_level
                                        & G1_BONDED}; // RULE_10 RULE_12
                    `PGFS_OFS_IRQ_STAT:
                        s_axi_rdata <= {24'h000000, irq_stat};
                    `PGFS_OFS_IRQ_MASK:
                        s_axi_rdata <= {24'h000000, irq_mask};
                    default:
                        s_axi_rdata <= 32'h0000_0000;
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule

/* src/pgfs_regs.vh */
`ifndef PGFS_REGS_VH
`define PGFS_REGS_VH
// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define PGFS_OFS_MODE     8'h00
`define PGFS_OFS_FUNC     8'h04
`define PGFS_OFS_G1DATA   8'h08
`define PGFS_OFS_IRQ_STAT 8'h0C
`define PGFS_OFS_IRQ_MASK 8'h10
// ----------------------------------------------------------------------
// reset values and field layout
// ----------------------------------------------------------------------
`define PGFS_RST_BYTE     8'h00
`define PGFS_RST_FUNC     16'h0000
`define PGFS_FN_TIMER     2'h0
`define PGFS_FN_UPMX      2'h1
`define PGFS_G1_OUT_LSB   8
`define PGFS_G1_IN_LSB    0
// edges after reset before pin-change detection is armed
`define PGFS_G1_WARM      2'h3
// bonded-pin masks, default = all eight pins present
`define PGFS_G0_BONDED    8'hFF
`define PGFS_G1_BONDED    8'hFF
// axi responses
`define PGFS_RESP_OKAY    2'h0
`define PGFS_RESP_SLVERR  2'h2
`endif

/* src/pgfs_pin_mux.v */
`timescale 1ns/1ps
// per-pin function routing for group 0
module pgfs_pin_mux #(
    parameter PIN = 0
) (
    // selection
    input  wire       periph_mode,
    input  wire [1:0] func_sel,
    // function 0 source/sink
    input  wire       fn0_out,
    input  wire       fn0_oe,
    // universal multiplexer
    input  wire       upmx_out,
    input  wire       upmx_oe,
    // gpio
    input  wire       gpio_out,
    input  wire       gpio_oe,
    // result
    output reg        pin_out,
    output reg        pin_oe,
    output wire       fn0_in_en,
    output wire       upmx_in_en
);
`include "pgfs_regs.vh"
    // function 0 exists on pins 0..5 only
    localparam HAS_FN0 = (PIN < 6);

    assign fn0_in_en  = periph_mode && (func_sel == `PGFS_FN_TIMER)
                        && HAS_FN0; // RULE_04
    assign upmx_in_en = periph_mode && (func_sel == `PGFS_FN_UPMX); // RULE_07

    // output selection; functions 2 and 3 leave the pin undriven
    always @* begin
        pin_out = 1'b0;
        pin_oe  = 1'b0;
        if (!periph_mode) begin // RULE_01
            pin_out = gpio_out;
            pin_oe  = gpio_oe;
        end else begin
            case (func_sel)
                `PGFS_FN_TIMER: begin // RULE_05 RULE_06
                    pin_out = HAS_FN0 ? fn0_out : 1'b0;
                    pin_oe  = HAS_FN0 ? fn0_oe : 1'b0;
                end
                `PGFS_FN_UPMX: begin // RULE_07
                    pin_out = upmx_out;
                    pin_oe  = upmx_oe;
                end
                default: begin
                    pin_out = 1'b0;
                    pin_oe  = 1'b0;
                end
            endcase
        end
    end
endmodule

/* bench/pgfs_properties.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// port checks for the pin function select block
// ----------------------------------------------------------------------
module pgfs_checker (
    // clock and reset
    input logic        aclk,
    input logic        aresetn,
    // bus handshakes
    input logic        s_axi_awready,
    input logic        s_axi_arready,
    input logic        s_axi_bvalid,
    input logic        s_axi_bready,
    input logic [1:0]  s_axi_bresp,
    input logic        s_axi_rvalid,
    input logic        s_axi_rready,
    input logic [31:0] s_axi_rdata,
    // pins
    input logic [7:0]  g0_pin_in,
    input logic [7:0]  g0_pin_oe,
    input logic [7:0]  g0_gpio_oe,
    input logic [7:0]  g0_gpio_in,
    input logic [1:0]  timer_ext_clock_in,
    input logic [7:0]  universal_pin_multiplexer_oe,
    input logic [7:0]  universal_pin_multiplexer_in,
    input logic [7:0]  g1_pin_out,
    input logic [7:0]  g1_gpio_oe
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // responses stand until taken
    chk_b_stands: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp lost");
    chk_r_stands: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata lost");
    chk_ar_to_r: assert property (s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    chk_aw_pulse: assert property (s_axi_awready |=> !s_axi_awready)
        else $error("awready held");
    chk_bresp_code: assert property (s_axi_bvalid
        |-> s_axi_bresp inside {2'h0, 2'h2}) else $error("bad bresp");
    // three edges of synchroniser between pin and timer input
    chk_timer_src: assert property (
        (timer_ext_clock_in & ~$past(g0_pin_in[1:0], 3)) == 2'h0)
        else $error("timer input without pin level");
    chk_gpio_gated: assert property (
        (g0_gpio_in[1:0] & timer_ext_clock_in) == 2'h0)
        else $error("pin seen by gpio and timer");
    chk_upmx_gated: assert property (
        (g0_gpio_in & universal_pin_multiplexer_in) == 8'h00)
        else $error("pin seen by gpio and multiplexer");
    // pins 0,1,6,7 have no driving function 0
    chk_fn0_undriven: assert property (((g0_pin_oe & 8'hC3) &
        ~$past(universal_pin_multiplexer_oe | g0_gpio_oe)) == 8'h00)
        else $error("pin driven without source");
    chk_g1_gate: assert property (
        (g1_pin_out & ~$past(g1_gpio_oe)) == 8'h00)
        else $error("group1 drive without enable");
    cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
    cover property (timer_ext_clock_in == 2'h3);
    cover property (g1_pin_out != 8'h00);
endmodule
bind pgfs_top pgfs_checker chk_i (.*);

/* bench/port_group_pin_function_select_test.sv */
`timescale 1ns/1ps
`include "pgfs_regs.vh"
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin \
 err_count++; $display("mismatch %s exp %h got %h", n, e, g); end end
module port_group_pin_function_select_test;
    logic        aclk, aresetn, s_axi_awvalid, s_axi_awready;
    logic        s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic        irq, buzzer_output, buzzer_output_n, buzzer_oe;
    logic [1:0]  s_axi_bresp, s_axi_rresp, resp, timer_ext_clock_in;
    logic [1:0]  converter_clock_out, converter_clock_oe;
    logic [3:0]  s_axi_wstrb;
    logic [7:0]  s_axi_awaddr, s_axi_araddr, g0_pin_in, g0_pin_out;
    logic [7:0]  g0_pin_oe, g0_gpio_out, g0_gpio_oe, g0_gpio_in;
    logic [7:0]  g1_pin_in, g1_pin_out, g1_gpio_oe;
    logic [7:0]  universal_pin_multiplexer_out, universal_pin_multiplexer_oe;
    logic [7:0]  universal_pin_multiplexer_in;
    logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
    int          err_count, checks_done, ready_lag;

    // pins 6 and 7 of group 1 left unbonded to exercise the masking
    pgfs_top #(
        .G1_BONDED (8'h3F)
    ) uut (.*);

    // 200 MHz clock
    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end
    // ------------------------------------------------------------------
    // bus tasks
    // ------------------------------------------------------------------
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic gone;
        err_count++;
        $display("mismatch bus wait exp answer got none");
        end_of_test;
    endtask
    task automatic w(input int n);
        repeat (n) @(posedge aclk);
    endtask
    // a spare edge first, so a strobe is never reassigned in one step
    task automatic wr(input [7:0] a, input [31:0] d, input [3:0] s);
        int n;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        {s_axi_awvalid, s_axi_wvalid} <= 2'h3;
        s_axi_bready <= (ready_lag == 0);
        n = 0;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (n == ready_lag) s_axi_bready <= 1'b1;
        end while (!(s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1)
                   && n < 40);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        if (n >= 40) gone;
    endtask
    task automatic rd(input [7:0] a);
        int n;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= (ready_lag == 0);
        n = 0;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (n == ready_lag) s_axi_rready <= 1'b1;
        end while (!(s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1)
                   && n < 40);
        {resp, rdat} = {s_axi_rresp, s_axi_rdata};
        s_axi_rready <= 1'b0;
        if (n >= 40) gone;
    endtask
    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_regs;
        rd(`PGFS_OFS_MODE);
        `CHK("mode reset", 32'h0, rdat)
        rd(`PGFS_OFS_FUNC);
        `CHK("func reset", 32'h0, rdat)
        rd(`PGFS_OFS_G1DATA);
        `CHK("g1 reset", 32'h0, rdat)
        wr(`PGFS_OFS_MODE, 32'hFFFFFFFF, 4'hF);
        rd(`PGFS_OFS_MODE);
        `CHK("mode rw", 32'h000000FF, rdat)
        wr(`PGFS_OFS_FUNC, 32'h0000A5C3, 4'hF);
        wr(`PGFS_OFS_FUNC, 32'h0000FFFF, 4'h1);
        rd(`PGFS_OFS_FUNC);
        `CHK("func lanes", 32'h0000A5FF, rdat)
    endtask
    task automatic t_gpio;
        wr(`PGFS_OFS_MODE, 32'h0, 4'hF);
        g0_gpio_out <= 8'h5A;
        g0_gpio_oe <= 8'hF0;
        g0_pin_in <= 8'h3C;
        w(5);
        `CHK("gpio out", 8'h5A, g0_pin_out)
        `CHK("gpio oe", 8'hF0, g0_pin_oe)
        `CHK("gpio in", 8'h3C, g0_gpio_in)
        `CHK("timer idle", 2'h0, timer_ext_clock_in)
    endtask
    task automatic t_fn0;
        wr(`PGFS_OFS_FUNC, 32'h0, 4'hF);
        wr(`PGFS_OFS_MODE, 32'hFF, 4'hF);
        {buzzer_output, buzzer_output_n, buzzer_oe} <= 3'h5;
        {converter_clock_out, converter_clock_oe} <= 4'hB;
        {universal_pin_multiplexer_out, universal_pin_multiplexer_oe}
            <= 16'hC3FF;
        g0_pin_in <= 8'h97;
        w(5);
        `CHK("timer in", 2'h3, timer_ext_clock_in)
        `CHK("buzzer pins", 2'h1, g0_pin_out[3:2])
        `CHK("clock pins", 2'h2, g0_pin_out[5:4])
        `CHK("fn0 oe", 8'h3C, g0_pin_oe)
        `CHK("fn0 gpio in", 8'h00, g0_gpio_in)
    endtask
    // function 1 to 3 on all pins at once
    task automatic t_fn123;
        logic [7:0] xp;
        for (int f = 1; f < 4; f++) begin
            wr(`PGFS_OFS_FUNC, {16'h0, {8{f[1:0]}}}, 4'hF);
            w(5);
            xp = (f == 1) ? 8'h97 : 8'h00;
            `CHK("fn oe", (f == 1) ? 8'hFF : 8'h00, g0_pin_oe)
            `CHK("fn in", xp, universal_pin_multiplexer_in)
            `CHK("fn timer", 2'h0, timer_ext_clock_in)
            if (f == 1) `CHK("fn out", 8'hC3, g0_pin_out)
        end
    endtask
    task automatic t_g1;
        g1_pin_in <= 8'hFC;
        g1_gpio_oe <= 8'hF0;
        wr(`PGFS_OFS_G1DATA, 32'h0000A5FF, 4'hF);
        w(5);
        rd(`PGFS_OFS_G1DATA);
        `CHK("g1 data", 32'h0000253C, rdat)
        `CHK("g1 pins", 8'h20, g1_pin_out)
    endtask
    // events stay sticky until cleared; mask gates the line
    task automatic t_irq;
        wr(`PGFS_OFS_IRQ_STAT, 32'hFF, 4'hF);
        wr(`PGFS_OFS_IRQ_MASK, 32'h0, 4'hF);
        g1_pin_in <= 8'h3D;
        w(6);
        rd(`PGFS_OFS_IRQ_STAT);
        `CHK("event", 32'h1, rdat)
        `CHK("masked irq", 1'b0, irq)
        wr(`PGFS_OFS_IRQ_MASK, 32'h1, 4'hF);
        w(3);
        `CHK("irq up", 1'b1, irq)
        wr(`PGFS_OFS_IRQ_STAT, 32'h1, 4'hF);
        w(3);
        `CHK("irq down", 1'b0, irq)
    endtask
    task automatic t_bad;
        ready_lag = 4; // late ready keeps each answer waiting
        wr(8'h20, 32'hFFFFFFFF, 4'hF);
        `CHK("bad wr resp", `PGFS_RESP_SLVERR, resp)
        rd(8'h20);
        `CHK("bad rd resp", `PGFS_RESP_SLVERR, resp)
        `CHK("bad rd data", 32'h0, rdat)
        ready_lag = 0;
    endtask
    // reset, then every scenario back to back
    initial begin
        {err_count, checks_done, ready_lag} = '0;
        {aresetn, s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb,
         s_axi_wvalid, s_axi_bready, s_axi_araddr, s_axi_arvalid,
         s_axi_rready, g0_pin_in, g0_gpio_out, g0_gpio_oe, buzzer_output,
         buzzer_output_n, buzzer_oe, converter_clock_out,
         converter_clock_oe, universal_pin_multiplexer_out,
         universal_pin_multiplexer_oe, g1_pin_in, g1_gpio_oe} = '0;
        w(6);
        aresetn <= 1'b1;
        t_regs;
        t_gpio;
        t_fn0;
        t_fn123;
        t_g1;
        t_irq;
        t_bad;
        end_of_test;
    end
endmodule
